// file: shared/acs_defines.vh
// register map, field positions, reset values and timing counts of the
// conversion sequencer; assumes a 32-bit byte-addressed register bus
`ifndef ACS_DEFINES_VH
`define ACS_DEFINES_VH

// byte offsets, one 32-bit word each, data in bits 7..0
`define ACS_OFS_CTRL_A   8'h00
`define ACS_OFS_CTRL_B   8'h04
`define ACS_OFS_RES_HI   8'h08
`define ACS_OFS_RES_LO   8'h0c
`define ACS_OFS_IRQ      8'h10

// conv_control_a fields
`define ACS_A_START      7
`define ACS_A_BUSY       6
`define ACS_A_POWER      5
`define ACS_A_ALIGN      4
`define ACS_A_CHAN_MSB   3

// conv_control_b fields
`define ACS_B_DIV_MSB    2

// irq control fields
`define ACS_I_CONV_EN    0
`define ACS_I_GLOB_EN    1
`define ACS_I_REQ        2

// power-on values
`define ACS_RST_CTRL_A   8'h00
`define ACS_RST_CTRL_B   8'h00
`define ACS_RST_RESULT   8'h00

// converter clock periods per conversion, and the sampling share of it
`define ACS_CONV_CLKS    5'h10
`define ACS_LAST_CLK     4'hf
`define ACS_SAMPLE_CLKS  4'h4

// external channels that exist; other codes leave the input floating
`define ACS_NUM_CHAN     4'h4

`endif

// file: hw/acs_sync.v
// two-flop synchroniser for a bus of independent pin levels
// assumes each bit is a slow level; no word coherence is promised
`timescale 1ns/1ps
module acs_sync #(
  parameter W = 12
) (
  input  wire         clk,
  input  wire         nrst,
  input  wire [W-1:0] d,
  output wire [W-1:0] q
);
  reg [W-1:0] meta_r;
  reg [W-1:0] hold_r;

  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      always @(posedge clk) begin
        if (!nrst) begin
          meta_r[i] <= 1'b0;
          hold_r[i] <= 1'b0;
        end else begin
          meta_r[i] <= d[i];
          hold_r[i] <= meta_r[i];
        end
      end
    end
  endgenerate

  assign q = hold_r;
endmodule

// file: hw/acs_clkdiv.v
// converter clock divider: one-cycle tick every 2**sel system clocks
// assumes run is synchronous to clk; the count restarts while run is low
`timescale 1ns/1ps
module acs_clkdiv (
  input  wire       clk,
  input  wire       nrst,
  input  wire       run,
  input  wire [2:0] sel,
  output wire       tick
);
  reg  [6:0] cnt_r;
  reg        tick_r;
  wire [7:0] span;
  wire [6:0] mask;
  wire       hit;

  // division by 1,2,4..128 for codes 000..111
  assign span = 8'h01 << sel;
  assign mask = span[6:0] - 7'h01;
  assign hit  = (cnt_r & mask) == mask;

  always @(posedge clk) begin
    if (!nrst) begin
      cnt_r  <= 7'h00;
      tick_r <= 1'b0;
    end else if (!run) begin
      cnt_r  <= 7'h00;
      tick_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_r + 7'h01;
      tick_r <= hit;
    end
  end

  assign tick = tick_r;
endmodule

// file: hw/acs_top.v
// conversion sequencer: wishbone registers, start detect, 16-period
// sample/convert timing, busy flag, result bytes and interrupt request
// assumes the analog SAR presents its 12-bit code on ADC_DATA, stable
// well before the last converter clock of a conversion
//
// Operation
// - start on a high-then-low pulse of start
// - busy rises at next converter clock edge
// - busy clears when conversion finishes
// - completion sets request; irq needs both enables
// - divider code selects system clock/1 to /128
// - conversion lasts exactly 16 converter clock periods
// - sampling phase then conversion phase each cycle
// - converter powered only while power enable high
// - busy may read zero, one, then zero
// - 12-bit unsigned result, full scale fff
// - alignment bit sets byte placement, unused zero
// - 4-bit channel code, missing channels float
// - result bytes unchanged while converter disabled
// - busy flag is read-only to software
//
// The placing of the registers and the Wishbone slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "acs_defines.vh"
module acs_top (
  input  wire        CLK,
  input  wire        NRST,
  input  wire        WB_CYC_I,
  input  wire        WB_STB_I,
  input  wire        WB_WE_I,
  input  wire [7:0]  WB_ADR_I,
  input  wire [3:0]  WB_SEL_I,
  input  wire [31:0] WB_DAT_I,
  output wire [31:0] WB_DAT_O,
  output wire        WB_ACK_O,
  input  wire [11:0] ADC_DATA,
  output wire        CONV_POWER,
  output wire [3:0]  CONV_CHANNEL,
  output wire        CONV_CHAN_VALID,
  output wire        CONV_SAMPLE,
  output wire        CONV_CLOCK_TICK,
  output wire        CONV_DONE,
  output wire        IRQ
);
  // register index codes
  localparam RI_NONE  = 3'h0;
  localparam RI_CTRLA = 3'h1;
  localparam RI_CTRLB = 3'h2;
  localparam RI_RESHI = 3'h3;
  localparam RI_RESLO = 3'h4;
  localparam RI_IRQ   = 3'h5;

  // sequencer states
  localparam ST_IDLE  = 2'h0;
  localparam ST_WAIT  = 2'h1;
  localparam ST_CONV  = 2'h2;

  // address decode shared by the read and write paths
  function [2:0] reg_index;
    input [7:0] adr;
    begin
      if (adr == `ACS_OFS_CTRL_A)
        reg_index = RI_CTRLA;
      else if (adr == `ACS_OFS_CTRL_B)
        reg_index = RI_CTRLB;
      else if (adr == `ACS_OFS_RES_HI)
        reg_index = RI_RESHI;
      else if (adr == `ACS_OFS_RES_LO)
        reg_index = RI_RESLO;
      else if (adr == `ACS_OFS_IRQ)
        reg_index = RI_IRQ;
      else
        reg_index = RI_NONE;
    end
  endfunction

  reg         start_r;
  reg         power_r;
  reg         align_r;
  reg  [3:0]  chan_r;
  reg  [4:0]  ctrlb_hi_r;
  reg  [2:0]  div_r;
  reg         irq_en_r;
  reg         glob_en_r;
  reg         irq_req_r;
  reg  [7:0]  res_hi_r;
  reg  [7:0]  res_lo_r;
  reg  [1:0]  state_r;
  reg  [1:0]  state_nxt;
  reg  [3:0]  cnt_r;
  reg  [3:0]  cnt_nxt;
  reg         done_r;
  reg         ack_r;
  reg  [7:0]  rdat_r;
  reg  [7:0]  rdat_nxt;

  wire        req;
  wire        wr_go;
  wire [2:0]  idx;
  wire        lane0;
  wire        wr_ctrla;
  wire        start_fall;
  wire        tick;
  wire        busy;
  wire        finish;
  wire [11:0] code;
  wire [7:0]  ctrla_rd;

  // bus handshake: ack follows a request by one cycle, then drops
  assign req   = WB_CYC_I & WB_STB_I;
  assign idx   = reg_index(WB_ADR_I);
  assign lane0 = WB_SEL_I[0];
  // writes land on the edge where the master sees ack
  assign wr_go = req & ack_r & WB_WE_I & lane0;
  assign wr_ctrla = wr_go & (idx == RI_CTRLA);

  // a written low while the bit holds high is the falling edge
  assign start_fall = wr_ctrla & start_r
                    & ~WB_DAT_I[`ACS_A_START];

  always @(posedge CLK) begin
    if (!NRST) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req & ~ack_r;
    end
  end

  // control registers; busy bit position is ignored on write
  always @(posedge CLK) begin
    if (!NRST) begin
      start_r    <= 1'b0;
      power_r    <= 1'b0;
      align_r    <= 1'b0;
      chan_r     <= 4'h0;
      ctrlb_hi_r <= 5'h00;
      div_r      <= 3'h0;
      irq_en_r   <= 1'b0;
      glob_en_r  <= 1'b0;
    end else if (wr_go) begin
      if (idx == RI_CTRLA) begin
        start_r <= WB_DAT_I[`ACS_A_START];
        power_r <= WB_DAT_I[`ACS_A_POWER];
        align_r <= WB_DAT_I[`ACS_A_ALIGN];
        chan_r  <= WB_DAT_I[`ACS_A_CHAN_MSB:0];
      end else if (idx == RI_CTRLB) begin
        ctrlb_hi_r <= WB_DAT_I[7:3];
        div_r      <= WB_DAT_I[`ACS_B_DIV_MSB:0];
      end else if (idx == RI_IRQ) begin
        irq_en_r  <= WB_DAT_I[`ACS_I_CONV_EN];
        glob_en_r <= WB_DAT_I[`ACS_I_GLOB_EN];
      end
    end
  end

  // converter clock, running only while powered
  acs_clkdiv u_div (
    .clk  (CLK),
    .nrst (NRST),
    .run  (power_r),
    .sel  (div_r),
    .tick (tick)
  );

  // sar code comes from outside the clock domain
  acs_sync #(
    .W (12)
  ) u_sync (
    .clk  (CLK),
    .nrst (NRST),
    .d    (ADC_DATA),
    .q    (code)
  );

  // sequencer: a start waits for the next converter clock edge before
  // busy shows, so a fast poll can see 0, then 1, then 0
  always @* begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    case (state_r)
      ST_IDLE: begin
        if (start_fall) begin
          state_nxt = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (tick) begin
          state_nxt = ST_CONV;
          cnt_nxt   = 4'h0;
        end
      end
      ST_CONV: begin
        if (start_fall) begin
          // restart from sampling at the next converter edge; a nonzero
          // count in the wait state keeps busy up meanwhile
          state_nxt = ST_WAIT;
          cnt_nxt   = `ACS_LAST_CLK;
        end else if (tick) begin
          if (cnt_r == `ACS_LAST_CLK) begin
            // idle always holds a zero count, so a fresh start shows
            // busy only at the next converter edge
            state_nxt = ST_IDLE;
            cnt_nxt   = 4'h0;
          end else begin
            cnt_nxt = cnt_r + 4'h1;
          end
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
    // dropping power abandons any conversion
    if (!power_r) begin
      state_nxt = ST_IDLE;
      cnt_nxt   = 4'h0;
    end
  end

  always @(posedge CLK) begin
    if (!NRST) begin
      state_r <= ST_IDLE;
      cnt_r   <= 4'h0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  // during a restart busy stays up, the count restarts at the edge
  assign busy = (state_r == ST_CONV)
              | ((state_r == ST_WAIT) & (cnt_r != 4'h0));

  // sixteenth converter period after the busy edge ends it
  assign finish = (state_r == ST_CONV) & tick & ~start_fall
                & (cnt_r == `ACS_LAST_CLK) & power_r;

  // first periods sample the selected input, the rest convert
  assign CONV_SAMPLE = (state_r == ST_CONV)
                     & (cnt_r < `ACS_SAMPLE_CLKS);

  // result bytes load together as busy falls; no load while off
  always @(posedge CLK) begin
    if (!NRST) begin
      res_hi_r <= `ACS_RST_RESULT;
      res_lo_r <= `ACS_RST_RESULT;
    end else if (finish) begin
      // 12-bit unsigned code, fff is full scale
      if (!align_r) begin
        // left-justified, low nibble of low byte zero
        res_hi_r <= code[11:4];
        res_lo_r <= {code[3:0], 4'h0};
      end else begin
        // right-justified, upper nibble of high byte zero
        res_hi_r <= {4'h0, code[11:8]};
        res_lo_r <= code[7:0];
      end
    end
  end

  // request flag: completion wins over a software clear
  always @(posedge CLK) begin
    if (!NRST) begin
      irq_req_r <= 1'b0;
      done_r    <= 1'b0;
    end else begin
      done_r <= finish;
      if (finish) begin
        irq_req_r <= 1'b1;
      end else if (wr_go & (idx == RI_IRQ)) begin
        irq_req_r <= WB_DAT_I[`ACS_I_REQ];
      end
    end
  end

  // interrupt only with both enables set
  assign IRQ = irq_req_r & irq_en_r & glob_en_r;

  // busy is read live from the sequencer
  assign ctrla_rd = {start_r, busy, power_r, align_r, chan_r};

  // read mux; unmapped offsets read zero
  always @* begin
    rdat_nxt = 8'h00;
    if (idx == RI_CTRLA)
      rdat_nxt = ctrla_rd;
    else if (idx == RI_CTRLB)
      rdat_nxt = {ctrlb_hi_r, div_r};
    else if (idx == RI_RESHI)
      rdat_nxt = res_hi_r;
    else if (idx == RI_RESLO)
      rdat_nxt = res_lo_r;
    else if (idx == RI_IRQ)
      rdat_nxt = {5'h00, irq_req_r, glob_en_r, irq_en_r};
  end

  always @(posedge CLK) begin
    if (!NRST) begin
      rdat_r <= 8'h00;
    end else if (req & ~ack_r) begin
      rdat_r <= rdat_nxt;
    end
  end

  assign WB_DAT_O = {24'h000000, rdat_r};
  assign WB_ACK_O = ack_r;

  // front-end controls; codes past the last channel float
  assign CONV_POWER      = power_r;
  assign CONV_CHANNEL    = chan_r;
  assign CONV_CHAN_VALID = chan_r < `ACS_NUM_CHAN;
  assign CONV_CLOCK_TICK = tick;
  assign CONV_DONE       = done_r;
endmodule

// file: testbench/acs_assertions.sv
// checker: bus handshake, converter timing and channel decode
// assumes it is bound to acs_top and sees only its ports
`timescale 1ns/1ps
module acs_chk (
  input wire logic       CLK,
  input wire logic       NRST,
  input wire logic       WB_CYC_I,
  input wire logic       WB_STB_I,
  input wire logic       WB_ACK_O,
  input wire logic       CONV_POWER,
  input wire logic [3:0] CONV_CHANNEL,
  input wire logic       CONV_CHAN_VALID,
  input wire logic       CONV_SAMPLE,
  input wire logic       CONV_CLOCK_TICK,
  input wire logic       CONV_DONE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  logic [4:0] cnt_r;
  // ticks since sampling began; saturates so a stalled run never wraps
  always @(posedge CLK)
    if (!NRST)
      cnt_r <= 5'h00;
    else if ($rose(CONV_SAMPLE))
      cnt_r <= {4'h0, CONV_CLOCK_TICK};
    else if (CONV_CLOCK_TICK && cnt_r != 5'h1f)
      cnt_r <= cnt_r + 5'h01;
  sequence s_req;
    WB_CYC_I && WB_STB_I && !WB_ACK_O;
  endsequence
  sequence s_off;
    !CONV_POWER ##1 !CONV_POWER;
  endsequence
  a_ack_follows: assert property (s_req |=> WB_ACK_O)
    else $error("ack missing after request");
  a_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property ($rose(WB_ACK_O) |-> $past(WB_STB_I))
    else $error("ack without strobe");
  a_chan_decode: assert property (
    CONV_CHAN_VALID == (CONV_CHANNEL < 4'h4))
    else $error("channel valid wrong");
  a_sample_four: assert property (
    $fell(CONV_SAMPLE) && CONV_POWER |-> cnt_r == 5'h04)
    else $error("sampling phase length wrong");
  a_done_sixteen: assert property (
    CONV_DONE |-> cnt_r inside {5'h10, 5'h11})
    else $error("conversion length wrong");
  a_done_single: assert property (CONV_DONE |=> !CONV_DONE)
    else $error("done longer than one cycle");
  a_tick_off: assert property (s_off |-> !CONV_CLOCK_TICK)
    else $error("converter clock while unpowered");
  a_sample_pwr: assert property ($rose(CONV_SAMPLE) |-> CONV_POWER)
    else $error("sampling while unpowered");
endmodule
bind acs_top acs_chk i_chk (
  .CLK(CLK), .NRST(NRST), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
  .WB_ACK_O(WB_ACK_O), .CONV_POWER(CONV_POWER),
  .CONV_CHANNEL(CONV_CHANNEL), .CONV_CHAN_VALID(CONV_CHAN_VALID),
  .CONV_SAMPLE(CONV_SAMPLE), .CONV_CLOCK_TICK(CONV_CLOCK_TICK),
  .CONV_DONE(CONV_DONE));

// file: testbench/acs_sar_model.sv
// analog source: one fixed level per existing channel
// assumes the bench only changes a level outside its conversion
`timescale 1ns/1ps
module acs_sar_model (
  input  wire logic        clk,
  input  wire logic        power,
  input  wire logic [3:0]  chan,
  input  wire logic [47:0] levels,
  output logic      [11:0] data
);
  logic [11:0] flt_r = 12'h5a3;
  // a floating or unpowered input has no stable code, so it keeps moving
  always @(posedge clk)
    flt_r <= ~flt_r;
  assign data = (power && chan < 4'h4) ?
                levels[chan*12 +: 12] : flt_r;
endmodule

// file: testbench/tb.sv
// self-checking bench for the conversion sequencer
// assumes acs_top, the analog source model and the bound checker
`timescale 1ns/1ps
`include "acs_defines.vh"
module tb;
  logic        clk = 0, nrst = 0, cyc = 0, stb = 0, we = 0;
  logic [7:0]  adr = 0;
  logic [31:0] dat = 0, q[$];
  logic [47:0] lv = 0;
  wire  [31:0] rdat;
  wire  [11:0] adc;
  wire  [3:0]  ch;
  wire         ack, pwr, cv, smp, tick, done, irq;
  int          n_fail = 0, total_checks = 0, cyc_n = 0, n_done = 0;
  acs_top i_dut (.CLK(clk), .NRST(nrst), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'h1), .WB_DAT_I(dat),
    .WB_DAT_O(rdat), .WB_ACK_O(ack), .ADC_DATA(adc), .CONV_POWER(pwr),
    .CONV_CHANNEL(ch), .CONV_CHAN_VALID(cv), .CONV_SAMPLE(smp),
    .CONV_CLOCK_TICK(tick), .CONV_DONE(done), .IRQ(irq));
  acs_sar_model i_sar (.clk(clk), .power(pwr), .chan(ch), .levels(lv),
    .data(adc));
  initial forever #12.5 clk = ~clk;
  task results;
    $display("checks %0d errors %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one classic cycle; release lands right after the ack edge
  task bus(input [7:0] a, input w, input [7:0] d);
    @(posedge clk);
    cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= {24'h0, d};
    do @(posedge clk); while (ack !== 1'b1);
    cyc <= 0; stb <= 0; we <= 0;
  endtask
  task rd(input [7:0] a, input [7:0] e);
    q.push_back({24'h0, e});
    bus(a, 1'b0, 8'h00);
  endtask
  task go(input [7:0] b);
    bus(`ACS_OFS_CTRL_A, 1'b1, b | 8'h80);
    bus(`ACS_OFS_CTRL_A, 1'b1, b);
  endtask
  task tk;
    do @(posedge clk); while (tick !== 1'b1);
  endtask
  function [15:0] fmt(input [11:0] d, input a);
    fmt = a ? {4'h0, d} : {d, 4'h0};
  endfunction
  always @(posedge clk) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      n_fail++;
      results;
    end
    if (ack === 1'b1 && !we && q.size() > 0)
      chk("read data", q.pop_front(), rdat);
    if (done === 1'b1)
      n_done++;
  end
  initial begin
    logic [11:0] v;
    logic [15:0] r;
    logic [7:0]  b;
    logic [2:0]  dv;
    logic [1:0]  c, ie;
    logic        al;
    int          n, nd;
    void'($urandom(32'hce26e4f3));
    repeat (20) @(posedge clk);
    nrst <= 1;
    for (int a = 0; a < 6; a++)
      rd(8'(a * 4), 8'h00);
    bus(8'h14, 1'b1, 8'hff);
    rd(8'h14, 8'h00);
    bus(8'h04, 1'b1, 8'hf8);
    rd(8'h04, 8'hf8);
    bus(8'h00, 1'b1, 8'h45);
    rd(8'h00, 8'h05);
    bus(8'h00, 1'b1, 8'h20);
    repeat (40) @(posedge clk);
    bus(8'h00, 1'b1, 8'ha0);
    repeat (30) @(posedge clk);
    chk("sample", 0, smp);
    // every divider code, also those outside the accurate range
    for (int i = 0; i < 8; i++) begin
      dv = 3'(i); c = 2'(i); al = dv[0]; ie = dv[2:1];
      v = (c == 2'h3) ? 12'hfff : 12'($urandom);
      lv[c*12 +: 12] <= v;
      b = {3'b001, al, 2'b00, c};
      bus(8'h04, 1'b1, {5'h0, dv});
      bus(8'h00, 1'b1, b);
      bus(8'h10, 1'b1, {6'h0, ie});
      nd = n_done;
      go(b);
      tk;
      n = 0;
      do begin @(posedge clk); n++; end while (tick !== 1'b1);
      chk("period", 1 << dv, n);
      rd(8'h00, b | 8'h40);
      while (n_done == nd) @(posedge clk);
      rd(8'h00, b);
      r = fmt(v, al);
      rd(8'h08, r[15:8]);
      rd(8'h0c, r[7:0]);
      chk("irq", {31'h0, &ie}, irq);
      rd(8'h10, {5'h0, 1'b1, ie});
      bus(8'h10, 1'b1, {6'h0, ie});
    end
    bus(8'h04, 1'b1, 8'h01);
    nd = n_done;
    go(b);
    repeat (10) tk;
    go(b);
    repeat (100) @(posedge clk);
    chk("done count", nd + 1, n_done);
    lv[c*12 +: 12] <= ~v;
    go(b);
    repeat (6) tk;
    bus(8'h00, 1'b1, b & 8'h1f);
    repeat (80) @(posedge clk);
    chk("done count", nd + 1, n_done);
    chk("power", 0, pwr);
    rd(8'h00, b & 8'h1f);
    rd(8'h08, r[15:8]);
    rd(8'h0c, r[7:0]);
    @(posedge clk);
    results;
  end
endmodule
